/* File: logic/ics_top.sv */
// Purpose: Interrupt entry and exit context shadow with enable and request
// Assumes: Core and event sources run on i_clk; Avalon-MM slave
// Notes:   One wait state on every bus access
// Operation
// - On interrupt entry push return PC to stack before routine starts
// - On entry copy W, STATUS without TO/PD, BANK_SELECT_REG, FSRs, PC_HIGH_LATCH to shadows
// - On return reload all saved registers from shadow copies
// - Shadow values written during routine are the ones restored
// - Shadow registers sit in bank 31, readable and writable
// - Enable register bits 7 to 4 enable logic cells four to one
// - Enable register eight bits, implemented bits read/write, zero on reset
// - Unimplemented enable bits 3-1 and request bits 5-1 read zero
// - Request flags bits 7, 6, 0 set by hardware, writable, reset zero
// - Oscillator-fail flag set on fail-safe event; only software clears it
// - Clock-switch flag set when new oscillator reports ready
module ics_top
	import ics_pkg::*;
(
	input  wire logic                          i_clk,
	input  wire logic                          i_reset_n,
	input  wire logic [ics_pkg::AV_ADDR_W-1:0] i_avs_address,
	input  wire logic                          i_avs_read,
	input  wire logic                          i_avs_write,
	input  wire logic [ics_pkg::AV_DATA_W-1:0] i_avs_writedata,
	output logic      [ics_pkg::AV_DATA_W-1:0] o_avs_readdata,
	output logic                               o_avs_waitrequest,
	input  wire logic                          i_irq_take,
	input  wire logic                          i_irq_return,
	input  wire logic [ics_pkg::PC_W-1:0]      i_ret_pc,
	input  wire logic [7:0]                    i_w,
	input  wire logic [7:0]                    i_status,
	input  wire logic [7:0]                    i_bsr,
	input  wire logic [7:0]                    i_pc_high_latch,
	input  wire logic [ics_pkg::FSR_W-1:0]     i_fsr0,
	input  wire logic [ics_pkg::FSR_W-1:0]     i_fsr1,
	input  wire logic                          i_osc_failsafe_evt,
	input  wire logic                          i_new_osc_ready,
	input  wire logic                          i_converter_done_evt,
	input  wire logic [3:0]                    i_logic_cell_flags,
	input  wire logic                          i_timer_gate_flag,
	input  wire logic [2:0]                    i_req_one_irq_en,
	output logic                               o_stack_push,
	output logic      [ics_pkg::PC_W-1:0]      o_stack_pc,
	output logic                               o_isr_start,
	output logic                               o_restore,
	output logic      [7:0]                    o_w,
	output logic      [7:0]                    o_status,
	output logic      [7:0]                    o_bsr,
	output logic      [7:0]                    o_pc_high_latch,
	output logic      [ics_pkg::FSR_W-1:0]     o_fsr0,
	output logic      [ics_pkg::FSR_W-1:0]     o_fsr1,
	output logic                               o_periph_irq,
	output logic                               o_irq
);
	import ics_pkg::*;

	ics_shadow_if sh ();

	ics_shadow_bank u_bank (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.sh        (sh.bank)
	);

	ics_state_type     state_r, state_nxt;
	logic              push_r, push_nxt;
	logic              start_r, start_nxt;
	logic              restore_r, restore_nxt;
	logic [PC_W-1:0]   pc_r, pc_nxt;
	logic [7:0]        periph_irq_enable_five_r, periph_irq_enable_five_nxt;
	logic [7:0]        periph_irq_request_one_r, periph_irq_request_one_nxt;
	logic [EV_W-1:0]   evt_r, evt_nxt;
	logic [EV_W-1:0]   evt_en_r, evt_en_nxt;
	logic [1:0]        ctrl_r, ctrl_nxt;
	logic              ack_r, ack_nxt;
	logic [7:0]        rdata_r, rdata_nxt;
	logic              rdy_prev_r;
	logic              entry, leave, wr_ok, csw_rise, in_bank;
	logic [EV_W-1:0]   evt_set;
	logic [7:0]        rsel;

	// Bus handshake: one wait cycle, then the access completes
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
	assign wr_ok    = i_avs_write & ack_r;
	assign in_bank  = i_avs_address >= OFS_BANK31_BASE &&
		i_avs_address <= OFS_BANK31_LAST && i_avs_address[1:0] == 2'h0;
	assign entry    = i_irq_take & (state_r == ST_IDLE);
	assign leave    = i_irq_return & (state_r == ST_ISR);
	assign csw_rise = i_new_osc_ready & ~rdy_prev_r;

	// Shadow bank access
	assign sh.save      = entry;
	assign sh.save_data = {i_pc_high_latch, i_fsr1, i_fsr0, i_bsr,
		i_status & STATUS_KEEP, i_w};
	assign sh.wr        = wr_ok & in_bank;
	assign sh.idx       = 3'(i_avs_address[4:2]);
	assign sh.wr_data   = i_avs_writedata[7:0];

	// Context sequence
	always_comb begin
		state_nxt   = state_r;
		push_nxt    = 1'b0;
		start_nxt   = 1'b0;
		restore_nxt = 1'b0;
		pc_nxt      = pc_r;
		case (state_r)
			ST_IDLE: begin
				if (entry) begin
					state_nxt = ST_ENTRY;
					push_nxt  = 1'b1;
					pc_nxt    = i_ret_pc;
				end
			end
			ST_ENTRY: begin
				state_nxt = ST_ISR;
				start_nxt = 1'b1;
			end
			ST_ISR: begin
				if (leave) begin
					state_nxt   = ST_EXIT;
					restore_nxt = 1'b1;
				end
			end
			ST_EXIT: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Restored values come straight from the shadow flops
	assign o_restore    = restore_r;
	assign o_w          = ics_slot(sh.held, SH_W);
	assign o_status     = ics_slot(sh.held, SH_STATUS);
	assign o_bsr        = ics_slot(sh.held, SH_BSR);
	assign o_pc_high_latch     = ics_slot(sh.held, SH_PC_HIGH_LATCH);
	assign o_fsr0       = {ics_slot(sh.held, SH_FSR0H),
		ics_slot(sh.held, SH_FSR0L)};
	assign o_fsr1       = {ics_slot(sh.held, SH_FSR1H),
		ics_slot(sh.held, SH_FSR1L)};
	assign o_stack_push = push_r;
	assign o_stack_pc   = pc_r;
	assign o_isr_start  = start_r;

	// Register file and flags
	always_comb begin
		periph_irq_enable_five_nxt   = periph_irq_enable_five_r;
		periph_irq_request_one_nxt   = periph_irq_request_one_r;
		evt_en_nxt = evt_en_r;
		ctrl_nxt   = ctrl_r;
		evt_nxt    = evt_r;
		evt_set    = '0;
		if (wr_ok) begin
			case (i_avs_address)
				OFS_PERIPH_IRQ_ENABLE_FIVE:   periph_irq_enable_five_nxt   = i_avs_writedata[7:0] & PERIPH_IRQ_ENABLE_FIVE_MASK;
				OFS_PERIPH_IRQ_REQUEST_ONE:   periph_irq_request_one_nxt   = i_avs_writedata[7:0] & PERIPH_IRQ_REQUEST_ONE_MASK;
				OFS_EVT_CLR: evt_nxt   = evt_r & ~i_avs_writedata[EV_W-1:0];
				OFS_EVT_EN: evt_en_nxt = i_avs_writedata[EV_W-1:0];
				OFS_CTRL:   ctrl_nxt   = i_avs_writedata[1:0];
				default:    ctrl_nxt   = ctrl_r;
			endcase
		end
		// Hardware sets win over a software write in the same cycle
		if (i_osc_failsafe_evt) begin
			periph_irq_request_one_nxt[PERIPH_IRQ_REQUEST_ONE_OSF] = 1'b1;
		end
		if (csw_rise) begin
			periph_irq_request_one_nxt[PERIPH_IRQ_REQUEST_ONE_CSW] = 1'b1;
		end
		if (i_converter_done_evt) begin
			periph_irq_request_one_nxt[PERIPH_IRQ_REQUEST_ONE_CONV] = 1'b1;
		end
		evt_set[EV_ENTRY] = entry;
		evt_set[EV_EXIT]  = leave;
		evt_set[EV_OSF]   = i_osc_failsafe_evt;
		evt_set[EV_CSW]   = csw_rise;
		evt_set[EV_CONV]  = i_converter_done_evt;
		evt_nxt = evt_nxt | evt_set;
	end

	// Read path
	always_comb begin
		rsel = REG_RESET;
		case (i_avs_address)
			OFS_PERIPH_IRQ_ENABLE_FIVE:     rsel = periph_irq_enable_five_r & PERIPH_IRQ_ENABLE_FIVE_MASK;
			OFS_PERIPH_IRQ_REQUEST_ONE:     rsel = periph_irq_request_one_r & PERIPH_IRQ_REQUEST_ONE_MASK;
			OFS_EVT_STAT: rsel = 8'(evt_r);
			OFS_EVT_EN:   rsel = 8'(evt_en_r);
			OFS_CTRL:     rsel = 8'(ctrl_r);
			default: begin
				if (in_bank) begin
					rsel = ics_slot(sh.held, sh.idx);
				end
			end
		endcase
		ack_nxt   = (i_avs_read | i_avs_write) & ~ack_r;
		rdata_nxt = (i_avs_read & ~ack_r) ? rsel : rdata_r;
	end
	assign o_avs_readdata = {24'h000000, rdata_r};

	// Interrupt outputs
	assign o_periph_irq = ctrl_r[CTRL_GIE] & ctrl_r[CTRL_PERIPHERAL_GROUP_ENABLE] &
		(|(periph_irq_enable_five_r[7:PERIPH_IRQ_ENABLE_FIVE_CELL_LO] & i_logic_cell_flags) |
		(periph_irq_enable_five_r[PERIPH_IRQ_ENABLE_FIVE_TGATE] & i_timer_gate_flag) |
		(i_req_one_irq_en[2] & periph_irq_request_one_r[PERIPH_IRQ_REQUEST_ONE_OSF]) |
		(i_req_one_irq_en[1] & periph_irq_request_one_r[PERIPH_IRQ_REQUEST_ONE_CSW]) |
		(i_req_one_irq_en[0] & periph_irq_request_one_r[PERIPH_IRQ_REQUEST_ONE_CONV]));
	assign o_irq = |(evt_r & evt_en_r);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r    <= ST_IDLE;
			push_r     <= 1'b0;
			start_r    <= 1'b0;
			restore_r  <= 1'b0;
			pc_r       <= '0;
			periph_irq_enable_five_r     <= REG_RESET;
			periph_irq_request_one_r     <= REG_RESET;
			evt_r      <= '0;
			evt_en_r   <= '0;
			ctrl_r     <= '0;
			ack_r      <= 1'b0;
			rdata_r    <= REG_RESET;
			rdy_prev_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			push_r     <= push_nxt;
			start_r    <= start_nxt;
			restore_r  <= restore_nxt;
			pc_r       <= pc_nxt;
			periph_irq_enable_five_r     <= periph_irq_enable_five_nxt;
			periph_irq_request_one_r     <= periph_irq_request_one_nxt;
			evt_r      <= evt_nxt;
			evt_en_r   <= evt_en_nxt;
			ctrl_r     <= ctrl_nxt;
			ack_r      <= ack_nxt;
			rdata_r    <= rdata_nxt;
			rdy_prev_r <= i_new_osc_ready;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	property p_push_pc;
		entry |=> o_stack_push && o_stack_pc == $past(i_ret_pc);
	endproperty
	a_push_pc: assert property (p_push_pc) else $error("pc not pushed");

	property p_push_first;
		o_stack_push |-> !o_isr_start ##1 o_isr_start && !o_stack_push;
	endproperty
	a_push_first: assert property (p_push_first) else $error("bad order");

	property p_save;
		entry |=> o_w == $past(i_w) && o_bsr == $past(i_bsr) &&
			o_fsr1 == $past(i_fsr1) && o_pc_high_latch == $past(i_pc_high_latch) &&
			o_status == ($past(i_status) & STATUS_KEEP);
	endproperty
	a_save: assert property (p_save) else $error("context not saved");

	property p_restore;
		leave |=> o_restore && o_fsr0 == $past(o_fsr0) ##1 !o_restore;
	endproperty
	a_restore: assert property (p_restore) else $error("no restore");

	property p_shadow_wr;
		wr_ok && i_avs_address == OFS_BANK31_BASE && !entry
			|=> o_w == $past(i_avs_writedata[7:0]);
	endproperty
	a_shadow_wr: assert property (p_shadow_wr) else $error("shadow wr");

	property p_bank_rd;
		i_avs_read && ack_r && i_avs_address == OFS_BANK31_BASE + 8'h04
			|-> o_avs_readdata[7:0] == o_status;
	endproperty
	a_bank_rd: assert property (p_bank_rd) else $error("bank read");

	property p_periph_irq_enable_five_wr;
		wr_ok && i_avs_address == OFS_PERIPH_IRQ_ENABLE_FIVE
			|=> periph_irq_enable_five_r == ($past(i_avs_writedata[7:0]) & PERIPH_IRQ_ENABLE_FIVE_MASK);
	endproperty
	a_periph_irq_enable_five_wr: assert property (p_periph_irq_enable_five_wr) else $error("enable wr");

	property p_unimpl;
		periph_irq_enable_five_r[3:1] == 3'h0 && periph_irq_request_one_r[5:1] == 5'h00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimpl bits set");

	property p_osf;
		i_osc_failsafe_evt |=> periph_irq_request_one_r[PERIPH_IRQ_REQUEST_ONE_OSF] && evt_r[EV_OSF];
	endproperty
	a_osf: assert property (p_osf) else $error("osf flag lost");

	property p_csw;
		$rose(i_new_osc_ready) |=> periph_irq_request_one_r[PERIPH_IRQ_REQUEST_ONE_CSW];
	endproperty
	a_csw: assert property (p_csw) else $error("csw flag lost");

	property p_conv;
		i_converter_done_evt |=> periph_irq_request_one_r[PERIPH_IRQ_REQUEST_ONE_CONV];
	endproperty
	a_conv: assert property (p_conv) else $error("conv flag lost");

	property p_gate;
		!ctrl_r[CTRL_GIE] || !ctrl_r[CTRL_PERIPHERAL_GROUP_ENABLE] |-> !o_periph_irq;
	endproperty
	a_gate: assert property (p_gate) else $error("irq not gated");
endmodule : ics_top

/* File: logic/ics_pkg.sv */
// Purpose: Shared constants and types of the interrupt context shadow block
// Assumes: Registers sit in the low byte of aligned 32-bit words
// Notes:   Byte addresses, field positions and reset values live here
package ics_pkg;
	localparam int          DATA_W          = 8;
	localparam int          AV_ADDR_W       = 8;
	localparam int          AV_DATA_W       = 32;
	localparam int          PC_W            = 15;
	localparam int          FSR_W           = 16;
	localparam int          SH_COUNT        = 8;
	localparam int          SH_IDX_W        = 3;
	localparam int          EV_W            = 5;

	// Register byte addresses
	localparam logic [7:0]  OFS_PERIPH_IRQ_ENABLE_FIVE        = 8'h00;
	localparam logic [7:0]  OFS_PERIPH_IRQ_REQUEST_ONE        = 8'h04;
	localparam logic [7:0]  OFS_EVT_STAT    = 8'h08;
	localparam logic [7:0]  OFS_EVT_CLR     = 8'h0c;
	localparam logic [7:0]  OFS_EVT_EN      = 8'h10;
	localparam logic [7:0]  OFS_CTRL        = 8'h14;
	// Shadow window standing for data memory bank 31
	localparam logic [7:0]  OFS_BANK31_BASE = 8'h20;
	localparam logic [7:0]  OFS_BANK31_LAST = 8'h3c;

	// Field layouts and reset values
	localparam logic [7:0]  PERIPH_IRQ_ENABLE_FIVE_MASK       = 8'hf1;
	localparam logic [7:0]  PERIPH_IRQ_REQUEST_ONE_MASK       = 8'hc1;
	localparam logic [7:0]  REG_RESET       = 8'h00;
	localparam int          PERIPH_IRQ_ENABLE_FIVE_TGATE      = 0;
	localparam int          PERIPH_IRQ_ENABLE_FIVE_CELL_LO    = 4;
	localparam int          PERIPH_IRQ_REQUEST_ONE_OSF        = 7;
	localparam int          PERIPH_IRQ_REQUEST_ONE_CSW        = 6;
	localparam int          PERIPH_IRQ_REQUEST_ONE_CONV       = 0;
	localparam logic [7:0]  STATUS_KEEP     = 8'he7;
	localparam int          CTRL_GIE        = 0;
	localparam int          CTRL_PERIPHERAL_GROUP_ENABLE       = 1;

	// Shadow slot indices
	localparam logic [2:0]  SH_W            = 3'h0;
	localparam logic [2:0]  SH_STATUS       = 3'h1;
	localparam logic [2:0]  SH_BSR          = 3'h2;
	localparam logic [2:0]  SH_FSR0L        = 3'h3;
	localparam logic [2:0]  SH_FSR0H        = 3'h4;
	localparam logic [2:0]  SH_FSR1L        = 3'h5;
	localparam logic [2:0]  SH_FSR1H        = 3'h6;
	localparam logic [2:0]  SH_PC_HIGH_LATCH       = 3'h7;

	// Event status bits
	localparam int          EV_ENTRY        = 0;
	localparam int          EV_EXIT         = 1;
	localparam int          EV_OSF          = 2;
	localparam int          EV_CSW          = 3;
	localparam int          EV_CONV         = 4;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ENTRY = 2'b01,
		ST_ISR   = 2'b11,
		ST_EXIT  = 2'b10
	} ics_state_type;

	function automatic logic [7:0] ics_slot(input logic [63:0] v,
		input logic [2:0] idx);
		ics_slot = v[idx*8 +: 8];
	endfunction : ics_slot
endpackage : ics_pkg

/* File: logic/ics_shadow_if.sv */
// Purpose: Carrier between the context controller and the shadow bank
// Assumes: One clock domain
// Notes:   Save has priority over a software write in the same cycle
interface ics_shadow_if;
	logic        save;
	logic [63:0] save_data;
	logic        wr;
	logic [2:0]  idx;
	logic [7:0]  wr_data;
	logic [63:0] held;

	modport ctrl (output save, save_data, wr, idx, wr_data, input held);
	modport bank (input save, save_data, wr, idx, wr_data, output held);
endinterface : ics_shadow_if

/* File: logic/ics_shadow_bank.sv */
// Purpose: Eight byte shadow copies of the core context
// Assumes: Save and software write come from the same clock
// Notes:   Storage is flip-flops addressed by slot index
module ics_shadow_bank
	import ics_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_reset_n,
	ics_shadow_if.bank sh
);
	logic [7:0] slot_r   [SH_COUNT];
	logic [7:0] slot_nxt [SH_COUNT];

	always_comb begin
		for (int i = 0; i < SH_COUNT; i++) begin
			slot_nxt[i] = slot_r[i];
			if (sh.save) begin
				slot_nxt[i] = ics_slot(sh.save_data, 3'(i));
			end else if (sh.wr && sh.idx == 3'(i)) begin
				slot_nxt[i] = sh.wr_data;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < SH_COUNT; i++) begin
				slot_r[i] <= REG_RESET;
			end
		end else begin
			slot_r <= slot_nxt;
		end
	end

	always_comb begin
		for (int i = 0; i < SH_COUNT; i++) begin
			sh.held[i*8 +: 8] = slot_r[i];
		end
	end
endmodule : ics_shadow_bank

/* File: tb/ics_core_model.sv */
// Purpose: Core side model driving interrupt entry, return and context
// Assumes: Driven just after rising edges of i_clk
// Notes:   Live context is altered inside the routine on purpose
module ics_core_model
	import ics_pkg::*;
(
	input  wire logic                     i_clk,
	output logic                          o_take,
	output logic                          o_ret,
	output logic      [ics_pkg::PC_W-1:0] o_pc,
	output logic      [63:0]              o_ctx
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_take = 1'b0;
		o_ret  = 1'b0;
		o_pc   = '0;
		o_ctx  = '0;
	end
	// One cycle take pulse with the context held for that edge
	task automatic enter(input logic [PC_W-1:0] pc, input logic [63:0] c);
		@(posedge i_clk);
		o_take <= 1'b1;
		o_pc   <= pc;
		o_ctx  <= c;
		@(posedge i_clk);
		o_take <= 1'b0;
		o_pc   <= ~pc;
		o_ctx  <= ~c;
	endtask : enter
	task automatic leave;
		@(posedge i_clk);
		o_ret <= 1'b1;
		@(posedge i_clk);
		o_ret <= 1'b0;
	endtask : leave
endmodule : ics_core_model

/* File: tb/ics_top_tb.sv */
// Purpose: Self-checking bench of the context shadow block
// Assumes: Avalon master with one outstanding access
// Notes:   Expected values come from a model held in integers
module ics_top_tb;
	import ics_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, rd, wr, osf, nrdy, conv, tg;
	logic        take, ret, wait_req, push, isr, restore, pirq, irq;
	logic [7:0]  addr, o_w, o_st, o_bsr, o_pcl;
	logic [31:0] wdata, rdata, seed, v, q;
	logic [14:0] pc, stack_pc;
	logic [15:0] o_f0, o_f1;
	logic [63:0] ctx, c;
	logic [3:0]  cells;
	logic [2:0]  ren;
	int          error_cnt, checks_done, e;
	ics_core_model u_core (.i_clk(clk), .o_take(take), .o_ret(ret),
		.o_pc(pc), .o_ctx(ctx));
	ics_top u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
		.i_irq_take(take), .i_irq_return(ret), .i_ret_pc(pc),
		.i_w(ctx[7:0]), .i_status(ctx[15:8]), .i_bsr(ctx[23:16]),
		.i_pc_high_latch(ctx[63:56]), .i_fsr0(ctx[39:24]), .i_fsr1(ctx[55:40]),
		.i_osc_failsafe_evt(osf), .i_new_osc_ready(nrdy),
		.i_converter_done_evt(conv), .i_logic_cell_flags(cells),
		.i_timer_gate_flag(tg), .i_req_one_irq_en(ren),
		.o_stack_push(push), .o_stack_pc(stack_pc), .o_isr_start(isr),
		.o_restore(restore), .o_w(o_w), .o_status(o_st), .o_bsr(o_bsr),
		.o_pc_high_latch(o_pcl), .o_fsr0(o_f0), .o_fsr1(o_f1),
		.o_periph_irq(pirq), .o_irq(irq));
	always #5 clk = ~clk;
	function automatic logic [31:0] rnd;
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input logic [63:0] s, input logic [63:0] x);
		checks_done++;
		if (s !== x) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, s, x);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		@(posedge clk);
		addr  <= a;
		rd    <= !w;
		wr    <= w;
		wdata <= {24'h0, d};
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 50);
		@(posedge clk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic rchk(input logic [7:0] a, input logic [7:0] x);
		bus(1'b0, a, 8'h00);
		chk(q, {24'h0, x});
	endtask : rchk
	task automatic pulse(input bit sel);
		@(posedge clk);
		if (sel) begin
			conv <= 1'b1;
		end else begin
			osf <= 1'b1;
		end
		@(posedge clk);
		osf  <= 1'b0;
		conv <= 1'b0;
	endtask : pulse
	task automatic wrap_up;
		$display("Errors %0d of %0d checks", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
	initial begin
		{clk, rst_n, rd, wr, osf, nrdy, conv, tg, cells, ren} = '0;
		addr = '0;
		wdata = '0;
		seed = 32'h8a657878;
		error_cnt = 0;
		checks_done = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rchk(OFS_PERIPH_IRQ_ENABLE_FIVE, REG_RESET);
		rchk(OFS_PERIPH_IRQ_REQUEST_ONE, REG_RESET);
		rchk(8'h18, 8'h00);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'hff : rnd();
			bus(1'b1, OFS_PERIPH_IRQ_ENABLE_FIVE, v[7:0]);
			rchk(OFS_PERIPH_IRQ_ENABLE_FIVE, v[7:0] & 8'hf1);
		end
		bus(1'b1, OFS_PERIPH_IRQ_REQUEST_ONE, 8'hff);
		rchk(OFS_PERIPH_IRQ_REQUEST_ONE, 8'hc1);
		bus(1'b1, OFS_PERIPH_IRQ_REQUEST_ONE, 8'h00);
		pulse(1'b0);
		repeat (3) rchk(OFS_PERIPH_IRQ_REQUEST_ONE, 8'h80);
		@(posedge clk);
		nrdy <= 1'b1;
		rchk(OFS_PERIPH_IRQ_REQUEST_ONE, 8'hc0);
		nrdy <= 1'b0;
		pulse(1'b1);
		rchk(OFS_PERIPH_IRQ_REQUEST_ONE, 8'hc1);
		bus(1'b1, OFS_PERIPH_IRQ_REQUEST_ONE, 8'h00);
		rchk(OFS_PERIPH_IRQ_REQUEST_ONE, 8'h00);
		for (int i = 0; i < 32; i++) begin
			v = rnd();
			bus(1'b1, OFS_PERIPH_IRQ_ENABLE_FIVE, v[7:0]);
			bus(1'b1, OFS_PERIPH_IRQ_REQUEST_ONE, v[15:8]);
			bus(1'b1, OFS_CTRL, {6'h0, v[17:16]});
			@(posedge clk);
			{ren, tg, cells} <= v[25:18];
			@(negedge clk);
			e = |(v[7:4] & v[21:18]) | (v[0] & v[22]) | (v[15] & v[25]);
			e = e | (v[14] & v[24]) | (v[8] & v[23]);
			chk(pirq, e & v[16] & v[17]);
		end
		for (int i = 0; i < 2; i++) begin
			c = {rnd(), rnd()};
			v = rnd();
			u_core.enter(v[14:0], c);
			@(negedge clk);
			chk({push, isr, stack_pc}, {2'b10, v[14:0]});
			@(negedge clk);
			chk({push, isr}, 2'b01);
			c[15:8] = c[15:8] & STATUS_KEEP;
			for (int k = 0; k < SH_COUNT; k++)
				rchk(OFS_BANK31_BASE + 8'(4 * k), c[k*8 +: 8]);
			v = rnd();
			c[7:0] = v[7:0];
			bus(1'b1, OFS_BANK31_BASE, v[7:0]);
			rchk(OFS_BANK31_BASE, v[7:0]);
			u_core.leave();
			@(negedge clk);
			chk(restore, 1'b1);
			chk({o_pcl, o_f1, o_f0, o_bsr, o_st, o_w}, c);
			repeat (2) @(posedge clk);
		end
		rchk(OFS_EVT_STAT, 8'h1f);
		bus(1'b1, OFS_EVT_EN, 8'h02);
		@(negedge clk);
		chk(irq, 1'b1);
		bus(1'b1, OFS_EVT_CLR, 8'h02);
		@(negedge clk);
		chk(irq, 1'b0);
		bus(1'b1, OFS_EVT_STAT, 8'h00);
		rchk(OFS_EVT_STAT, 8'h1d);
		rchk(OFS_EVT_CLR, 8'h00);
		bus(1'b1, OFS_PERIPH_IRQ_ENABLE_FIVE, 8'hff);
		bus(1'b1, OFS_PERIPH_IRQ_REQUEST_ONE, 8'hff);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rchk(OFS_PERIPH_IRQ_ENABLE_FIVE, REG_RESET);
		rchk(OFS_PERIPH_IRQ_REQUEST_ONE, REG_RESET);
		wrap_up();
	end
endmodule : ics_top_tb
